// ---- hw/hpp_pkg.sv ----
// Package of register map, field layout, modes and timing constants for the parallel port
package hpp_pkg;
   localparam int HPP_WIDTH = 16;
   localparam int HPP_PORTS = 2;
   localparam logic [11:0] HPP_OFF_DATA0 = 12'h000;
   localparam logic [11:0] HPP_OFF_CTRL0 = 12'h004;
   localparam logic [11:0] HPP_OFF_DATA1 = 12'h008;
   localparam logic [11:0] HPP_OFF_CTRL1 = 12'h00c;
   localparam logic [11:0] HPP_OFF_DIR0 = 12'h010;
   localparam logic [11:0] HPP_OFF_DIR1 = 12'h014;
   localparam logic [11:0] HPP_OFF_TMO0 = 12'h018;
   localparam logic [11:0] HPP_OFF_TMO1 = 12'h01c;
   localparam logic [11:0] HPP_OFF_ISTAT = 12'h020;
   localparam logic [11:0] HPP_OFF_IEN = 12'h024;
   localparam logic [11:0] HPP_OFF_ICLR = 12'h028;
   localparam logic [11:0] HPP_PORT_STRIDE = 12'h008;
   // Control word fields
   localparam int HPP_CTRL_MODE_LSB = 0;
   localparam int HPP_CTRL_OPEN_BIT = 2;
   localparam int HPP_CTRL_CLOSE_BIT = 3;
   localparam int HPP_CTRL_BUSY_BIT = 4;
   localparam int HPP_CTRL_DONE_BIT = 5;
   localparam int HPP_CTRL_TMO_BIT = 6;
   localparam int HPP_CTRL_FLAG_BIT = 7;
   localparam int HPP_CTRL_OE_BIT = 8;
   localparam int HPP_TMO_WIDTH = 15;
   localparam logic [14:0] HPP_TMO_MAX = 15'h7fff;
   localparam logic [14:0] HPP_TMO_RESET = 15'h7fff;
   // Timeout unit: one wait step lasts this many nanoseconds, 20 clock cycles at the 50 ns clock
   localparam int HPP_TICK_NS = 1000;
   localparam int HPP_CLK_NS = 50;
   localparam int HPP_TICK_CYCLES = (HPP_TICK_NS + HPP_CLK_NS - 1) / HPP_CLK_NS;
   localparam int HPP_IRQ_BITS = 2 * HPP_PORTS;
   typedef enum logic [1:0] {
      HPP_MODE_NONE = 2'b00,
      HPP_MODE_HS_IN = 2'b01,
      HPP_MODE_HS_OUT = 2'b10,
      HPP_MODE_STB_OUT = 2'b11
   } hpp_mode_t;
   typedef enum logic [1:0] {
      HPP_ST_IDLE = 2'b00,
      HPP_ST_WAIT_ACK = 2'b01,
      HPP_ST_WAIT_REL = 2'b10
   } hpp_state_t;
endpackage

// ---- hw/hpp_port.sv ----
// One independent 16-bit handshaked parallel port channel
`timescale 1ns/1ps
`default_nettype none
module hpp_port #(
   parameter int WIDTH = hpp_pkg::HPP_WIDTH,
   parameter int TICK_CYCLES = hpp_pkg::HPP_TICK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic open_req,
   input wire logic close_req,
   input wire hpp_pkg::hpp_mode_t mode_in,
   input wire logic [WIDTH-1:0] dir_in,
   input wire logic [hpp_pkg::HPP_TMO_WIDTH-1:0] tmo_in,
   input wire logic data_wr,
   input wire logic [WIDTH-1:0] data_wdata,
   input wire logic data_rd,
   output logic [WIDTH-1:0] out_latch,
   output logic [WIDTH-1:0] in_latch,
   output logic [WIDTH-1:0] dir_mask,
   output hpp_pkg::hpp_mode_t mode,
   output logic is_open,
   output logic busy,
   output logic done_pulse,
   output logic tmo_pulse,
   input wire logic [WIDTH-1:0] port_data_line_i,
   output logic [WIDTH-1:0] port_data_line_o,
   output logic [WIDTH-1:0] port_data_line_oe,
   input wire logic external_flag_in,
   input wire logic output_enable_in_n,
   output logic control_strobe_out,
   output logic direction_indicator_out
);
   import hpp_pkg::*;
   hpp_state_t state;
   logic [HPP_TMO_WIDTH-1:0] tmo_set;
   logic [HPP_TMO_WIDTH-1:0] wait_cnt;
   logic [15:0] tick_cnt;
   logic start;
   logic ack;
   logic rel;
   logic tick;
   // Output transfers start on a data write, input transfers on a data read
   assign start = is_open && (state == HPP_ST_IDLE) && (mode != HPP_MODE_NONE) &&
                  (mode == HPP_MODE_HS_IN ? data_rd : data_wr);
   assign ack = external_flag_in;
   assign rel = !external_flag_in;
   assign tick = (tick_cnt == 16'(TICK_CYCLES - 1));

   // Open programs mode, direction, wait; close returns to power-up state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         is_open <= 1'b0;
         mode <= HPP_MODE_NONE;
         dir_mask <= '0;
         tmo_set <= HPP_TMO_RESET;
      end else if (close_req) begin
         is_open <= 1'b0;
         mode <= HPP_MODE_NONE;
         dir_mask <= '0;
         tmo_set <= HPP_TMO_RESET;
      end else if (open_req) begin
         is_open <= 1'b1;
         mode <= mode_in;
         dir_mask <= dir_in;
         tmo_set <= tmo_in;
      end
   end

   // Output latch, readable back, one drives high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_latch <= '0;
      end else if (close_req) begin
         out_latch <= '0;
      end else if (data_wr && (state == HPP_ST_IDLE)) begin
         out_latch <= data_wdata;
      end
   end

   // Pins driven only on bits set as output, and only while the far end enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_data_line_o <= '0;
         port_data_line_oe <= '0;
         direction_indicator_out <= 1'b0;
         in_latch <= '0;
      end else begin
         port_data_line_o <= out_latch;
         port_data_line_oe <= (is_open && !output_enable_in_n) ? dir_mask : '0;
         direction_indicator_out <= is_open && (mode == HPP_MODE_HS_OUT || mode == HPP_MODE_STB_OUT);
         // Input side: in no-handshake mode sample freely; in handshake input mode capture on flag
         if (mode == HPP_MODE_NONE || (state == HPP_ST_WAIT_ACK && ack && mode == HPP_MODE_HS_IN)) begin
            in_latch <= port_data_line_i & ~dir_mask;
         end
      end
   end

   // Wait prescaler runs only during a handshake
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= '0;
      end else if (state == HPP_ST_IDLE || tick) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + 16'h0001;
      end
   end

   // Handshake sequencer; strobe output needs no acknowledge release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= HPP_ST_IDLE;
         control_strobe_out <= 1'b0;
         wait_cnt <= '0;
         busy <= 1'b0;
         done_pulse <= 1'b0;
         tmo_pulse <= 1'b0;
      end else begin
         done_pulse <= 1'b0;
         tmo_pulse <= 1'b0;
         case (state)
            HPP_ST_IDLE: begin
               if (close_req) begin
                  control_strobe_out <= 1'b0;
               end else if (start) begin
                  state <= HPP_ST_WAIT_ACK;
                  control_strobe_out <= 1'b1;
                  wait_cnt <= tmo_set;
                  busy <= 1'b1;
               end
            end
            HPP_ST_WAIT_ACK: begin
               if (close_req) begin
                  state <= HPP_ST_IDLE;
                  control_strobe_out <= 1'b0;
                  busy <= 1'b0;
               end else if (ack || mode == HPP_MODE_STB_OUT) begin
                  control_strobe_out <= 1'b0;
                  state <= (mode == HPP_MODE_STB_OUT) ? HPP_ST_IDLE : HPP_ST_WAIT_REL;
                  busy <= (mode != HPP_MODE_STB_OUT);
                  done_pulse <= (mode == HPP_MODE_STB_OUT);
               end else if (tick) begin
                  if (wait_cnt == '0) begin
                     state <= HPP_ST_IDLE;
                     control_strobe_out <= 1'b0;
                     busy <= 1'b0;
                     tmo_pulse <= 1'b1;
                  end else begin
                     wait_cnt <= wait_cnt - 15'h0001;
                  end
               end
            end
            HPP_ST_WAIT_REL: begin
               if (close_req || rel) begin
                  state <= HPP_ST_IDLE;
                  busy <= 1'b0;
                  done_pulse <= !close_req;
               end else if (tick) begin
                  if (wait_cnt == '0) begin
                     state <= HPP_ST_IDLE;
                     busy <= 1'b0;
                     tmo_pulse <= 1'b1;
                  end else begin
                     wait_cnt <= wait_cnt - 15'h0001;
                  end
               end
            end
            default: begin
               state <= HPP_ST_IDLE;
               control_strobe_out <= 1'b0;
               busy <= 1'b0;
            end
         endcase
      end
   end

   a_strobe_clear: assert property (@(posedge pclk) disable iff (!presetn)
      close_req |=> !control_strobe_out && !busy) else $error("close left handshake active");
   a_dir_gate: assert property (@(posedge pclk) disable iff (!presetn)
      (port_data_line_oe & ~$past(dir_mask)) == '0) else $error("input bit driven");
endmodule
`default_nettype wire

// ---- hw/hpp_top.sv ----
// APB slave with two handshaked 16-bit parallel ports and an interrupt
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module hpp_top #(
   parameter int WIDTH = hpp_pkg::HPP_WIDTH,
   parameter int TICK_CYCLES = hpp_pkg::HPP_TICK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic [hpp_pkg::HPP_PORTS*WIDTH-1:0] port_data_line_i,
   output logic [hpp_pkg::HPP_PORTS*WIDTH-1:0] port_data_line_o,
   output logic [hpp_pkg::HPP_PORTS*WIDTH-1:0] port_data_line_oe,
   input wire logic [hpp_pkg::HPP_PORTS-1:0] external_flag_in,
   input wire logic [hpp_pkg::HPP_PORTS-1:0] output_enable_in_n,
   output logic [hpp_pkg::HPP_PORTS-1:0] control_strobe_out,
   output logic [hpp_pkg::HPP_PORTS-1:0] direction_indicator_out
);
   import hpp_pkg::*;
   localparam int NP = HPP_PORTS;
   logic setup;
   logic wr;
   logic rd;
   logic [NP-1:0] open_req;
   logic [NP-1:0] close_req;
   logic [NP-1:0] data_wr;
   logic [NP-1:0] data_rd;
   logic [NP-1:0] busy;
   logic [NP-1:0] is_open;
   logic [NP-1:0] done_pulse;
   logic [NP-1:0] tmo_pulse;
   logic [NP-1:0] dir_wr;
   logic [NP-1:0] tmo_wr;
   logic [WIDTH-1:0] out_latch [NP];
   logic [WIDTH-1:0] in_latch [NP];
   logic [WIDTH-1:0] dir_mask [NP];
   logic [WIDTH-1:0] dir_stage [NP];
   logic [HPP_TMO_WIDTH-1:0] tmo_stage [NP];
   hpp_mode_t mode [NP];
   logic [HPP_IRQ_BITS-1:0] istat;
   logic [HPP_IRQ_BITS-1:0] ien;
   logic [HPP_IRQ_BITS-1:0] ev;
   logic [HPP_IRQ_BITS-1:0] iclr;
   logic [31:0] next_prdata;
   logic next_err;

   // Valid register offset check, used for error decode of both reads and writes
   function automatic logic hpp_mapped(input logic [11:0] a);
      hpp_mapped = (a <= HPP_OFF_ICLR) && (a[1:0] == 2'b00);
   endfunction

   // Single-cycle access: setup then access with pready high
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite && pready;
   assign rd = psel && penable && !pwrite && pready;
   assign iclr = (wr && paddr == HPP_OFF_ICLR) ? pwdata[HPP_IRQ_BITS-1:0] : '0;

   genvar g;
   generate
      for (g = 0; g < NP; g++) begin : gen_port
         logic [11:0] dbase;
         assign dbase = 12'(g) * HPP_PORT_STRIDE;
         // Each port has a data word and a control word
         assign data_wr[g] = wr && paddr == HPP_OFF_DATA0 + dbase;
         assign data_rd[g] = rd && paddr == HPP_OFF_DATA0 + dbase;
         assign open_req[g] = wr && paddr == HPP_OFF_CTRL0 + dbase && pwdata[HPP_CTRL_OPEN_BIT];
         assign close_req[g] = wr && paddr == HPP_OFF_CTRL0 + dbase && pwdata[HPP_CTRL_CLOSE_BIT];
         assign dir_wr[g] = wr && paddr == HPP_OFF_DIR0 + 12'(g * 4);
         assign tmo_wr[g] = wr && paddr == HPP_OFF_TMO0 + 12'(g * 4);
         assign ev[2*g] = done_pulse[g];
         assign ev[2*g+1] = tmo_pulse[g];

         // Staged settings take effect on the next open
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               dir_stage[g] <= '0;
               tmo_stage[g] <= HPP_TMO_RESET;
            end else begin
               if (dir_wr[g]) begin
                  dir_stage[g] <= pwdata[WIDTH-1:0];
               end
               if (tmo_wr[g]) begin
                  tmo_stage[g] <= pwdata[HPP_TMO_WIDTH-1:0];
               end
            end
         end

         // Two identical, independent channels
         hpp_port #(.WIDTH(WIDTH), .TICK_CYCLES(TICK_CYCLES)) u_port (
            .pclk(pclk),
            .presetn(presetn),
            .open_req(open_req[g]),
            .close_req(close_req[g]),
            .mode_in(hpp_mode_t'(pwdata[HPP_CTRL_MODE_LSB +: 2])),
            .dir_in(dir_stage[g]),
            .tmo_in(tmo_stage[g]),
            .data_wr(data_wr[g]),
            .data_wdata(pwdata[WIDTH-1:0]),
            .data_rd(data_rd[g]),
            .out_latch(out_latch[g]),
            .in_latch(in_latch[g]),
            .dir_mask(dir_mask[g]),
            .mode(mode[g]),
            .is_open(is_open[g]),
            .busy(busy[g]),
            .done_pulse(done_pulse[g]),
            .tmo_pulse(tmo_pulse[g]),
            .port_data_line_i(port_data_line_i[g*WIDTH +: WIDTH]),
            .port_data_line_o(port_data_line_o[g*WIDTH +: WIDTH]),
            .port_data_line_oe(port_data_line_oe[g*WIDTH +: WIDTH]),
            .external_flag_in(external_flag_in[g]),
            .output_enable_in_n(output_enable_in_n[g]),
            .control_strobe_out(control_strobe_out[g]),
            .direction_indicator_out(direction_indicator_out[g])
         );
      end
   endgenerate

   // Read mux; data word returns output bits from output latch, input bits from input latch
   always_comb begin
      next_prdata = 32'h0000_0000;
      next_err = !hpp_mapped(paddr);
      for (int i = 0; i < NP; i++) begin
         if (paddr == HPP_OFF_DATA0 + 12'(i * 8)) begin
            next_prdata[WIDTH-1:0] = (out_latch[i] & dir_mask[i]) | (in_latch[i] & ~dir_mask[i]);
         end
         if (paddr == HPP_OFF_CTRL0 + 12'(i * 8)) begin
            next_prdata[HPP_CTRL_MODE_LSB +: 2] = mode[i];
            next_prdata[HPP_CTRL_OPEN_BIT] = is_open[i];
            next_prdata[HPP_CTRL_BUSY_BIT] = busy[i];
            next_prdata[HPP_CTRL_DONE_BIT] = istat[2*i];
            next_prdata[HPP_CTRL_TMO_BIT] = istat[2*i+1];
            next_prdata[HPP_CTRL_FLAG_BIT] = external_flag_in[i];
            next_prdata[HPP_CTRL_OE_BIT] = !output_enable_in_n[i];
         end
         if (paddr == HPP_OFF_DIR0 + 12'(i * 4)) begin
            next_prdata[WIDTH-1:0] = dir_stage[i];
         end
         if (paddr == HPP_OFF_TMO0 + 12'(i * 4)) begin
            next_prdata[HPP_TMO_WIDTH-1:0] = tmo_stage[i];
         end
      end
      if (paddr == HPP_OFF_ISTAT) begin
         next_prdata[HPP_IRQ_BITS-1:0] = istat;
      end
      if (paddr == HPP_OFF_IEN) begin
         next_prdata[HPP_IRQ_BITS-1:0] = ien;
      end
   end

   // Answer registered in setup so that outputs come from flip-flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         prdata <= (setup && !pwrite) ? next_prdata : 32'h0000_0000;
         pslverr <= setup && next_err;
      end
   end

   // Sticky events; a new event beats a same-cycle clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat <= '0;
         ien <= '0;
         irq <= 1'b0;
      end else begin
         istat <= (istat & ~iclr) | ev;
         if (wr && paddr == HPP_OFF_IEN) begin
            ien <= pwdata[HPP_IRQ_BITS-1:0];
         end
         irq <= |(((istat & ~iclr) | ev) & ien);
      end
   end

   a_ready_setup: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready) else $error("no ready after setup");
   a_ready_only: assert property (@(posedge pclk) disable iff (!presetn)
      pready |-> $past(psel && !penable)) else $error("ready without setup");
   a_latch_back: assert property (@(posedge pclk) disable iff (!presetn)
      (data_wr[0] && !busy[0]) |=> out_latch[0] == $past(pwdata[WIDTH-1:0])) else $error("latch lost");
   a_pin_high: assert property (@(posedge pclk) disable iff (!presetn)
      data_wr[0] && !busy[0] |=> ##1 port_data_line_o[WIDTH-1:0] == $past(pwdata[WIDTH-1:0], 2)) else $error("pin");
   a_close_passive: assert property (@(posedge pclk) disable iff (!presetn)
      close_req[1] |=> !is_open[1] ##1 port_data_line_oe[2*WIDTH-1:WIDTH] == '0) else $error("close");
   a_open_mode: assert property (@(posedge pclk) disable iff (!presetn)
      (open_req[0] && !close_req[0]) |=> mode[0] == $past(pwdata[1:0]) && is_open[0]) else $error("mode");
   a_sticky_set: assert property (@(posedge pclk) disable iff (!presetn)
      tmo_pulse[1] |=> istat[3]) else $error("event lost");
   // Level follows the status it was built from, one enable update behind
   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      irq == |(istat & $past(ien))) else $error("irq mismatch");
   a_split_ports: assert property (@(posedge pclk) disable iff (!presetn)
      data_wr[0] |=> $stable(out_latch[1])) else $error("ports coupled");
endmodule
`default_nettype wire

// ---- testbench/hpp_instr_model.sv ----
// Behavioural external instrument on one 16-bit parallel cable
`timescale 1ns/1ps
`default_nettype none
module hpp_instr_model #(
   parameter int DELAY = 0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic answer,
   input wire logic enable,
   input wire logic [15:0] drv,
   input wire logic strobe,
   input wire logic [15:0] dev_o,
   input wire logic [15:0] dev_oe,
   output logic flag,
   output logic oe_n,
   output logic [15:0] level
);
   int cnt;
   // Driver enable from the bench; the device still decides per bit
   assign oe_n = !enable;
   // Instrument drives only where the device has let go
   assign level = (dev_o & dev_oe) | (drv & ~dev_oe);
   // Answers a request after DELAY cycles, or never when answer is low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag <= 1'b0;
         cnt <= 0;
      end else if (flag) begin
         if (!strobe) flag <= 1'b0;
      end else if (strobe && answer) begin
         if (cnt >= DELAY) begin
            flag <= 1'b1;
            cnt <= 0;
         end else cnt <= cnt + 1;
      end else cnt <= 0;
   end
endmodule
`default_nettype wire

// ---- testbench/hpp_top_tb_top.sv ----
// Register-level testbench of the handshaked parallel port
`timescale 1ns/1ps
`default_nettype none
module hpp_top_tb_top;
   import hpp_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, irq;
   wire logic [31:0] pin_i;
   logic [31:0] pin_o, pin_oe;
   wire logic [1:0] flag, oe_n;
   logic [1:0] strobe, dir_ind;
   logic [1:0] answer = 2'b11;
   logic [1:0] drv_en = 2'b11;
   logic [31:0] rd;
   logic err;
   int errors = 0;
   int num_checks = 0;
   initial forever #25 pclk = ~pclk;
   hpp_top #(.TICK_CYCLES(1)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .port_data_line_i(pin_i), .port_data_line_o(pin_o), .port_data_line_oe(pin_oe),
      .external_flag_in(flag), .output_enable_in_n(oe_n), .control_strobe_out(strobe),
      .direction_indicator_out(dir_ind));
   // Slow instrument on port 0, prompt one on port 1
   hpp_instr_model #(.DELAY(3)) u_inst0 (.pclk(pclk), .presetn(presetn), .answer(answer[0]), .enable(drv_en[0]),
      .drv(16'h3c5a), .strobe(strobe[0]), .dev_o(pin_o[15:0]), .dev_oe(pin_oe[15:0]), .flag(flag[0]),
      .oe_n(oe_n[0]), .level(pin_i[15:0]));
   hpp_instr_model #(.DELAY(0)) u_inst1 (.pclk(pclk), .presetn(presetn), .answer(answer[1]), .enable(drv_en[1]),
      .drv(16'h9617), .strobe(strobe[1]), .dev_o(pin_o[31:16]), .dev_oe(pin_oe[31:16]), .flag(flag[1]),
      .oe_n(oe_n[1]), .level(pin_i[31:16]));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("FAIL at %0t got %h expected %h", $time, got, exp);
         errors++;
      end
   endtask
   // One APB transfer; holds the request until pready is sampled high
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 20) errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0);
      chk(rd & m, exp);
   endtask
   // Poll interrupt status until a bit appears, bounded
   task automatic wait_ev(input int b);
      int n;
      n = 0;
      rd = 32'h0;
      while (rd[b] !== 1'b1 && n < 60) begin
         xfer(HPP_OFF_ISTAT, 1'b0, 32'h0);
         n++;
      end
      chk({31'h0, rd[b]}, 32'h1);
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(HPP_OFF_CTRL0, 32'h7, 32'h0);
      rdc(HPP_OFF_TMO0, 32'hffff, 32'h7fff);
      rdc(HPP_OFF_ISTAT, 32'hf, 32'h0);
      xfer(12'h02c, 1'b0, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("test reset done");
      // Mode 0: low byte out, high byte in, no handshake
      wr(HPP_OFF_DIR0, 32'h00ff);
      wr(HPP_OFF_CTRL0, 32'h4);
      wr(HPP_OFF_DATA0, 32'ha5c3);
      chk(pin_oe[15:0], 32'h00ff);
      chk(strobe[0], 1'b0);
      // Far end withdraws its enable: drivers must let go
      drv_en[0] <= 1'b0;
      rdc(HPP_OFF_CTRL0, 32'h100, 32'h0);
      chk(pin_oe[15:0], 32'h0);
      drv_en[0] <= 1'b1;
      rdc(HPP_OFF_DATA0, 32'hffff, 32'h3cc3);
      chk(pin_o[15:0], 32'ha5c3);
      $display("test mode0 done");
      // Mode 2 with slow partner, interrupt raised and cleared
      wr(HPP_OFF_IEN, 32'hf);
      wr(HPP_OFF_DIR0, 32'hffff);
      wr(HPP_OFF_CTRL0, 32'h6);
      // Indicator is two flops behind the write; let it settle
      @(posedge pclk);
      chk(dir_ind[0], 1'b1);
      wr(HPP_OFF_DATA0, 32'h1234);
      wait_ev(0);
      chk(pin_o[15:0], 32'h1234);
      chk(irq, 1'b1);
      wr(HPP_OFF_IEN, 32'h0);
      rdc(HPP_OFF_ISTAT, 32'h1, 32'h1);
      chk(irq, 1'b0);
      wr(HPP_OFF_IEN, 32'hf);
      wr(HPP_OFF_ICLR, 32'h1);
      rdc(HPP_OFF_ISTAT, 32'hf, 32'h0);
      chk(irq, 1'b0);
      $display("test mode2 done");
      // Mode 1: a read starts the input handshake
      wr(HPP_OFF_DIR0, 32'h0);
      wr(HPP_OFF_CTRL0, 32'h5);
      @(posedge pclk);
      chk(dir_ind[0], 1'b0);
      xfer(HPP_OFF_DATA0, 1'b0, 32'h0);
      wait_ev(0);
      rdc(HPP_OFF_DATA0, 32'hffff, 32'h3c5a);
      wr(HPP_OFF_ICLR, 32'hf);
      $display("test mode1 done");
      // Port 1: no answer ends in timeout, port 0 untouched
      answer[1] <= 1'b0;
      wr(HPP_OFF_TMO1, 32'h2);
      wr(HPP_OFF_DIR1, 32'hffff);
      wr(HPP_OFF_CTRL1, 32'h6);
      wr(HPP_OFF_DATA1, 32'hbeef);
      wait_ev(3);
      rdc(HPP_OFF_CTRL1, 32'h40, 32'h40);
      chk(strobe[1], 1'b0);
      chk(pin_oe[15:0], 32'h0);
      // Mode 3 strobe output
      answer[1] <= 1'b1;
      wr(HPP_OFF_CTRL1, 32'h7);
      wr(HPP_OFF_DATA1, 32'h0f0f);
      wait_ev(2);
      chk(pin_o[31:16], 32'h0f0f);
      $display("test port1 done");
      // Close returns port 0 to its power-up state
      wr(HPP_OFF_CTRL0, 32'hc);
      rdc(HPP_OFF_CTRL0, 32'h7, 32'h0);
      chk({pin_o[15:0], pin_oe[15:0]}, 32'h0);
      chk({strobe[0], dir_ind[0]}, 2'b00);
      chk(pin_o[31:16], 32'h0f0f);
      wr(HPP_OFF_CTRL1, 32'h8);
      rdc(HPP_OFF_CTRL1, 32'h7, 32'h0);
      chk(pin_oe[31:16], 32'h0);
      $display("test close done");
      stop_test();
   end
   initial begin
      #1000000;
      errors++;
      stop_test();
   end
endmodule
`default_nettype wire
